/* File: verilog/fifo_port_device.sv */
// Device end of the parallel FIFO port: buffers, strobes, status, power
`include "usb_fifo_port_cfg.svh"

//------------------------------------------------------------------------
// Device end
//------------------------------------------------------------------------
// Overview of operation
// - Power enable low once configured
// - Power enable high during suspend
// - Drive receive byte while read low
// - Read falling edge fetches next byte
// - Write falling edge captures bus byte
// - Host writes only when space shown
// - Host pulses write high then low
// - Transmit space pin floats in reset
// - Host reads only when data waiting
// - Waiting low when unread bytes; host strobes
// - Data waiting pin floats in reset
// - Suspend with wakeup: waiting pin inputs
// - Low twenty ms requests bus resume
// - Optional weak pull-low during suspend
// - Host may reset through reset input
module fifo_port_device
   import usb_fifo_port_pkg::*;
#(
   parameter int WAKE_CYCLES = `WAKE_LOW_CYCLES
) (
   input  wire logic               sys_clk_in,
   input  wire logic               arst_n_in,
   fifo_port_if.device             link,
   input  wire logic [`DATA_W-1:0] rx_data_in,
   input  wire logic               rx_valid_in,
   output logic                    rx_ready_out,
   output logic      [`DATA_W-1:0] tx_data_out,
   output logic                    tx_valid_out,
   input  wire logic               tx_ready_in,
   input  wire logic               usb_configured_in,
   input  wire logic               usb_suspend_in,
   input  wire logic               remote_wakeup_en_in,
   input  wire logic               suspend_pulldown_en_in,
   output logic                    resume_request_out
);

   //---------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------
   logic                 rd_n_d_ff;
   logic                 wr_d_ff;
   logic                 rd_fall;
   logic                 wr_fall;
   logic [`DATA_W-1:0]   rx_head;
   logic                 rx_head_valid;
   logic                 rx_pop;
   logic                 tx_in_ready;
   logic [`DATA_W-1:0]   rd_byte_ff;
   logic                 data_oe_ff;
   logic                 running_ff;
   logic                 txe_n_ff;
   logic                 rxf_n_ff;
   logic                 power_switch_enable_n_n_ff;
   logic                 pull_low_ff;
   logic                 wake_mode_ff;
   logic                 nxt_wake_mode;
   wake_state_t          wake_state_ff;
   logic [`WAKE_CNT_W-1:0] wake_cnt_ff;
   logic                 wake_last;
   logic                 resume_ff;

   //---------------------------------------------------------------------
   // Strobe edge detection
   //---------------------------------------------------------------------
   // Previous strobe levels
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_n_d_ff <= `STROBE_RD_RST;
         wr_d_ff   <= `STROBE_WR_RST;
      end else begin
         rd_n_d_ff <= link.rd_n;
         wr_d_ff   <= link.wr;
      end
   end

   assign rd_fall = rd_n_d_ff & ~link.rd_n;
   assign wr_fall = wr_d_ff & ~link.wr;

   //---------------------------------------------------------------------
   // Receive buffer: USB side fills, pin side drains
   //---------------------------------------------------------------------
   // pop only if a byte is there
   assign rx_pop = rd_fall & rx_head_valid;

   byte_fifo #(
      .WIDTH (`DATA_W),
      .DEPTH (`BUF_DEPTH)
   ) u_rx_buf (
      .sys_clk_in    (sys_clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (rx_valid_in),
      .in_ready_out  (rx_ready_out),
      .in_data_in    (rx_data_in),
      .out_valid_out (rx_head_valid),
      .out_ready_in  (rx_pop),
      .out_data_out  (rx_head)
   );

   //---------------------------------------------------------------------
   // Transmit buffer: pin side fills, USB side drains
   //---------------------------------------------------------------------
   // capture; byte is dropped if host ignores space status
   byte_fifo #(
      .WIDTH (`DATA_W),
      .DEPTH (`BUF_DEPTH)
   ) u_tx_buf (
      .sys_clk_in    (sys_clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (wr_fall),
      .in_ready_out  (tx_in_ready),
      .in_data_in    (link.fifo_data_bus),
      .out_valid_out (tx_valid_out),
      .out_ready_in  (tx_ready_in),
      .out_data_out  (tx_data_out)
   );

   //---------------------------------------------------------------------
   // Data bus drive
   //---------------------------------------------------------------------
   // latch the fetched byte
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_byte_ff <= '0;
      end else if (rx_pop) begin
         rd_byte_ff <= rx_head;
      end
   end

   // drive only while read strobe low
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         data_oe_ff <= 1'b0;
      end else begin
         data_oe_ff <= ~link.rd_n;
      end
   end

   assign link.dev_data    = rd_byte_ff;
   assign link.dev_data_oe = data_oe_ff;

   //---------------------------------------------------------------------
   // Status pins
   //---------------------------------------------------------------------
   // Running flag; low only inside reset
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         running_ff <= 1'b0;
      end else begin
         running_ff <= 1'b1;
      end
   end

   // space shown low only with room; high just after a write
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         txe_n_ff <= `STATUS_RST;
      end else begin
         txe_n_ff <= ~tx_in_ready | wr_fall;
      end
   end

   // waiting low with unread bytes, high during a read
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rxf_n_ff <= `STATUS_RST;
      end else begin
         rxf_n_ff <= ~(rx_head_valid & link.rd_n & ~rd_fall);
      end
   end

   assign link.transmit_space_n       = txe_n_ff;
   assign link.receive_data_waiting_n = rxf_n_ff;
   assign link.transmit_space_oe      = running_ff;
   // float in reset and in wakeup input mode
   assign link.receive_data_waiting_oe = running_ff & ~wake_mode_ff;

   //---------------------------------------------------------------------
   // Power switch and suspend pulls
   //---------------------------------------------------------------------
   // low when configured and awake
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_switch_enable_n_n_ff <= `STATUS_RST;
      end else begin
         power_switch_enable_n_n_ff <= ~(usb_configured_in & ~usb_suspend_in);
      end
   end

   // weak pulls go low in suspend when chosen
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pull_low_ff <= 1'b0;
      end else begin
         pull_low_ff <= suspend_pulldown_en_in & usb_suspend_in;
      end
   end

   assign link.power_switch_enable_n = power_switch_enable_n_n_ff;
   assign link.pull_low              = pull_low_ff;

   //---------------------------------------------------------------------
   // Remote wakeup
   //---------------------------------------------------------------------
   // input mode: option on, suspended, power enable high
   assign nxt_wake_mode = remote_wakeup_en_in & usb_suspend_in & power_switch_enable_n_n_ff;
   assign wake_last     = (wake_cnt_ff == `WAKE_CNT_W'(WAKE_CYCLES - 1));

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wake_mode_ff <= 1'b0;
      end else begin
         wake_mode_ff <= nxt_wake_mode;
      end
   end

   // count consecutive low samples of the waiting pin
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wake_state_ff <= WAKE_IDLE;
         wake_cnt_ff   <= '0;
      end else if (!wake_mode_ff) begin
         wake_state_ff <= WAKE_IDLE;
         wake_cnt_ff   <= '0;
      end else begin
         unique case (wake_state_ff)
            WAKE_IDLE: begin
               wake_cnt_ff <= '0;
               if (!link.receive_data_waiting_pin) begin
                  wake_state_ff <= WAKE_COUNT;
               end
            end
            WAKE_COUNT: begin
               if (link.receive_data_waiting_pin) begin
                  wake_state_ff <= WAKE_IDLE;
               end else if (wake_last) begin
                  wake_state_ff <= WAKE_SENT;
               end else begin
                  wake_cnt_ff <= wake_cnt_ff + 1'b1;
               end
            end
            WAKE_SENT: begin
               if (link.receive_data_waiting_pin) begin
                  wake_state_ff <= WAKE_IDLE;
               end
            end
            default: begin
               wake_state_ff <= WAKE_IDLE;
            end
         endcase
      end
   end

   // one resume pulse per held-low episode
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         resume_ff <= 1'b0;
      end else begin
         resume_ff <= wake_mode_ff & (wake_state_ff == WAKE_COUNT) &
                      ~link.receive_data_waiting_pin & wake_last;
      end
   end

   assign resume_request_out = resume_ff;

endmodule : fifo_port_device

/* File: verilog/usb_fifo_port_cfg.svh */
// Constants shared by both ends of the byte-wide parallel FIFO port
`ifndef USB_FIFO_PORT_CFG_SVH
`define USB_FIFO_PORT_CFG_SVH

// Data path shape
`define DATA_W          8
`define BUF_DEPTH       8

// System clock rate
`define CLK_HZ          40000000

// Remote wakeup: least low time of the waiting pin, in ms and in cycles
`define WAKE_LOW_MS     20
`define WAKE_LOW_CYCLES ((`WAKE_LOW_MS * `CLK_HZ + 999) / 1000)
`define WAKE_CNT_W      20
`define HOST_WAKE_EXTRA 2

// Host strobe phase length in cycles
`define STROBE_CYCLES   3
`define STROBE_CNT_W    2

// Reset values of the pins
`define STROBE_RD_RST   1'b1
`define STROBE_WR_RST   1'b0
`define STATUS_RST      1'b1

`endif

/* File: verilog/usb_fifo_port_pkg.sv */
// Types shared by both ends of the parallel FIFO port
package usb_fifo_port_pkg;

   // Remote wakeup detector states
   typedef enum logic [1:0] {WAKE_IDLE, WAKE_COUNT, WAKE_SENT} wake_state_t;

   // Host sequencer states
   typedef enum logic [2:0] {
      H_IDLE, H_WR_HIGH, H_WR_HOLD, H_RD_LOW, H_RD_REC, H_WAKE
   } host_state_t;

endpackage : usb_fifo_port_pkg

/* File: verilog/fifo_port_if.sv */
// Pins between the FIFO port device and the external logic
interface fifo_port_if;
   logic [7:0] dev_data;                  // Device side of the data bus
   logic       dev_data_oe;
   logic [7:0] host_data;                 // Host side of the data bus
   logic       host_data_oe;
   logic [7:0] fifo_data_bus;             // Resolved bus level
   logic       rd_n;                      // Read strobe, active low
   logic       wr;                        // Transmit strobe, falling edge
   logic       transmit_space_n;
   logic       transmit_space_oe;
   logic       transmit_space_pin;        // Resolved level
   logic       receive_data_waiting_n;
   logic       receive_data_waiting_oe;
   logic       host_wake_n;               // Host drive in wakeup
   logic       host_wake_oe;
   logic       receive_data_waiting_pin;  // Resolved level
   logic       power_switch_enable_n;
   logic       pull_low;                  // Weak pulls go low
   logic       idle_lvl;

   // Weak pull level of undriven pins
   assign idle_lvl = ~pull_low;
   assign fifo_data_bus = dev_data_oe  ? dev_data  :
                          host_data_oe ? host_data : {8{idle_lvl}};
   assign transmit_space_pin = transmit_space_oe ? transmit_space_n : idle_lvl;
   assign receive_data_waiting_pin =
      receive_data_waiting_oe ? receive_data_waiting_n :
      host_wake_oe            ? host_wake_n            : idle_lvl;

   modport device (
      output dev_data, dev_data_oe, transmit_space_n, transmit_space_oe,
             receive_data_waiting_n, receive_data_waiting_oe,
             power_switch_enable_n, pull_low,
      input  fifo_data_bus, rd_n, wr, receive_data_waiting_pin
   );

   modport host (
      output host_data, host_data_oe, rd_n, wr, host_wake_n, host_wake_oe,
      input  fifo_data_bus, transmit_space_pin, receive_data_waiting_pin,
             power_switch_enable_n
   );
endinterface : fifo_port_if

/* File: verilog/byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic [AW:0]      nxt_count;
   logic             push;
   logic             pop;

   // Pointer advance with wrap
   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] ptr);
      next_ptr = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
   endfunction : next_ptr

   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;
   assign out_data_out = mem[rd_ptr_ff];

   // Occupancy after this cycle
   always_comb begin
      nxt_count = count_ff;
      if (push & ~pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop & ~push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   // Storage
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_in;
      end
   end

   // Pointers, count and registered flags
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_ff     <= '0;
         rd_ptr_ff     <= '0;
         count_ff      <= '0;
         in_ready_out  <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         if (push) wr_ptr_ff <= next_ptr(wr_ptr_ff);
         if (pop)  rd_ptr_ff <= next_ptr(rd_ptr_ff);
         count_ff      <= nxt_count;
         in_ready_out  <= (nxt_count != (AW + 1)'(DEPTH));
         out_valid_out <= (nxt_count != '0);
      end
   end
endmodule : byte_fifo

/* File: verilog/fifo_port_host.sv */
// External-logic end of the parallel FIFO port: strobe sequencer
`include "usb_fifo_port_cfg.svh"

module fifo_port_host
   import usb_fifo_port_pkg::*;
#(
   parameter int WAKE_HOLD = `WAKE_LOW_CYCLES + `HOST_WAKE_EXTRA
) (
   input  wire logic               sys_clk_in,
   input  wire logic               arst_n_in,
   fifo_port_if.host               link,
   input  wire logic [`DATA_W-1:0] send_data_in,
   input  wire logic               send_valid_in,
   output logic                    send_ready_out,
   input  wire logic               recv_req_in,
   output logic      [`DATA_W-1:0] recv_data_out,
   output logic                    recv_valid_out,
   input  wire logic               wake_req_in,
   output logic                    link_suspended_out
);

   //---------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------
   host_state_t              state_ff;
   host_state_t              nxt_state;
   logic [`STROBE_CNT_W-1:0] strb_cnt_ff;
   logic [`WAKE_CNT_W-1:0]   wake_cnt_ff;
   logic                     strb_done;
   logic                     wake_done;
   logic                     take_send;
   logic                     start_read;
   logic                     start_wake;
   logic [`DATA_W-1:0]       data_ff;
   logic                     data_oe_ff;
   logic                     rd_n_ff;
   logic                     wr_ff;
   logic                     wake_oe_ff;

   assign strb_done = (strb_cnt_ff == `STROBE_CNT_W'(`STROBE_CYCLES - 1));
   assign wake_done = (wake_cnt_ff == `WAKE_CNT_W'(WAKE_HOLD - 1));

   assign take_send  = (state_ff == H_IDLE) & send_valid_in & send_ready_out &
                       ~link.transmit_space_pin;
   assign start_read = (state_ff == H_IDLE) & ~take_send & recv_req_in &
                       ~link.receive_data_waiting_pin & ~link.power_switch_enable_n;
   assign start_wake = (state_ff == H_IDLE) & ~take_send & ~start_read &
                       wake_req_in & link.power_switch_enable_n;

   //---------------------------------------------------------------------
   // Sequencer
   //---------------------------------------------------------------------
   // Next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         H_IDLE: begin
            if (take_send)       nxt_state = H_WR_HIGH;
            else if (start_read) nxt_state = H_RD_LOW;
            else if (start_wake) nxt_state = H_WAKE;
         end
         H_WR_HIGH: if (strb_done) nxt_state = H_WR_HOLD;
         H_WR_HOLD: if (strb_done) nxt_state = H_IDLE;
         H_RD_LOW:  if (strb_done) nxt_state = H_RD_REC;
         H_RD_REC:  if (strb_done) nxt_state = H_IDLE;
         H_WAKE:    if (wake_done) nxt_state = H_IDLE;
         default:   nxt_state = H_IDLE;
      endcase
   end

   // State and phase counters
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_ff    <= H_IDLE;
         strb_cnt_ff <= '0;
         wake_cnt_ff <= '0;
      end else begin
         state_ff    <= nxt_state;
         strb_cnt_ff <= (nxt_state != state_ff) ? '0 : strb_cnt_ff + 1'b1;
         wake_cnt_ff <= (state_ff == H_WAKE) ? wake_cnt_ff + 1'b1 : '0;
      end
   end

   // write strobe high then low; data held through the low edge
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ff      <= `STROBE_WR_RST;
         data_ff    <= '0;
         data_oe_ff <= 1'b0;
      end else begin
         wr_ff      <= (nxt_state == H_WR_HIGH);
         data_oe_ff <= (nxt_state == H_WR_HIGH) | (nxt_state == H_WR_HOLD);
         if (take_send) data_ff <= send_data_in;
      end
   end

   // read strobe low, sample byte, back high
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_n_ff        <= `STROBE_RD_RST;
         recv_data_out  <= '0;
         recv_valid_out <= 1'b0;
      end else begin
         rd_n_ff        <= (nxt_state != H_RD_LOW);
         recv_valid_out <= (state_ff == H_RD_LOW) & strb_done;
         if ((state_ff == H_RD_LOW) & strb_done) begin
            recv_data_out <= link.fifo_data_bus;
         end
      end
   end

   // hold waiting pin low for the wake time
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wake_oe_ff <= 1'b0;
      end else begin
         wake_oe_ff <= (nxt_state == H_WAKE);
      end
   end

   // User status flags
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         send_ready_out     <= 1'b0;
         link_suspended_out <= 1'b1;
      end else begin
         send_ready_out     <= (nxt_state == H_IDLE) & ~take_send;
         link_suspended_out <= link.power_switch_enable_n;
      end
   end

   assign link.host_data    = data_ff;
   assign link.host_data_oe = data_oe_ff;
   assign link.rd_n         = rd_n_ff;
   assign link.wr           = wr_ff;
   assign link.host_wake_n  = 1'b0;
   assign link.host_wake_oe = wake_oe_ff;

endmodule : fifo_port_host

/* File: sim/fifo_port_chk.sv */
// Concurrent checks on the pins between the two port ends
module fifo_port_chk #(
   parameter int WAKE_CYCLES = 20
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic rd_n,
   input wire logic wr,
   input wire logic dev_data_oe,
   input wire logic transmit_space_n,
   input wire logic transmit_space_oe,
   input wire logic receive_data_waiting_oe,
   input wire logic receive_data_waiting_pin,
   input wire logic power_switch_enable_n,
   input wire logic pull_low,
   input wire logic usb_configured_in,
   input wire logic usb_suspend_in,
   input wire logic remote_wakeup_en_in,
   input wire logic suspend_pulldown_en_in,
   input wire logic resume_request_out
);
   int low_cnt;

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   // Run of low samples on the released waiting pin
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         low_cnt <= 0;
      else if (!receive_data_waiting_oe && !receive_data_waiting_pin)
         low_cnt <= low_cnt + 1;
      else
         low_cnt <= 0;
   end

   //---------------------------------------------------------------------
   // Pin behaviour
   //---------------------------------------------------------------------
   property p_float_rst;
      disable iff (1'b0) !arst_n_in |-> !transmit_space_oe && !receive_data_waiting_oe;
   endproperty
   a_float_rst: assert property (p_float_rst)
      else $error("status pin driven in reset");
   property p_rd_drive;
      !rd_n |=> dev_data_oe;
   endproperty
   a_rd_drive: assert property (p_rd_drive)
      else $error("bus not driven in read");
   property p_rd_release;
      rd_n |=> !dev_data_oe;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("bus not released");
   property p_wr_space;
      $fell(wr) |=> transmit_space_n;
   endproperty
   a_wr_space: assert property (p_wr_space)
      else $error("space not withdrawn after write");
   property p_power;
      power_switch_enable_n == !$past(usb_configured_in && !usb_suspend_in);
   endproperty
   a_power: assert property (p_power)
      else $error("power enable wrong");
   property p_pull;
      pull_low == $past(suspend_pulldown_en_in && usb_suspend_in);
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull level wrong");
   property p_wake_in;
      (remote_wakeup_en_in && usb_suspend_in && power_switch_enable_n) [*2]
         |=> !receive_data_waiting_oe;
   endproperty
   a_wake_in: assert property (p_wake_in)
      else $error("waiting pin still driven");
   property p_wake_res;
      low_cnt == WAKE_CYCLES - 1 && !receive_data_waiting_pin |-> ##[1:4] resume_request_out;
   endproperty
   a_wake_res: assert property (p_wake_res)
      else $error("no resume request");
endmodule : fifo_port_chk

/* File: sim/testbench.sv */
// Self-checking bench for both ends of the parallel FIFO port
`include "usb_fifo_port_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk_in = 1'b0;
   logic        arst_n_in = 1'b1;
   logic [7:0]  rx_data_in, tx_data_out, send_data_in, recv_data_out;
   logic        rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in, resume_request_out;
   logic        usb_configured_in, usb_suspend_in, remote_wakeup_en_in, suspend_pulldown_en_in;
   logic        send_valid_in, send_ready_out, recv_req_in, recv_valid_out;
   logic        wake_req_in, link_suspended_out;
   logic [31:0] rnd = 32'hb579;
   logic [7:0]  q[$];
   int          mismatches, cmp_count, n, i;

   fifo_port_if link ();
   fifo_port_device #(.WAKE_CYCLES(20)) fifo_port_device_i (.sys_clk_in, .arst_n_in,
      .link(link), .rx_data_in, .rx_valid_in, .rx_ready_out, .tx_data_out, .tx_valid_out,
      .tx_ready_in, .usb_configured_in, .usb_suspend_in, .remote_wakeup_en_in,
      .suspend_pulldown_en_in, .resume_request_out);
   fifo_port_host #(.WAKE_HOLD(22)) fifo_port_host_i (.sys_clk_in, .arst_n_in,
      .link(link), .send_data_in, .send_valid_in, .send_ready_out, .recv_req_in,
      .recv_data_out, .recv_valid_out, .wake_req_in, .link_suspended_out);
   fifo_port_chk #(.WAKE_CYCLES(20)) fifo_port_chk_i (.sys_clk_in, .arst_n_in,
      .rd_n(link.rd_n), .wr(link.wr), .dev_data_oe(link.dev_data_oe),
      .transmit_space_n(link.transmit_space_n), .transmit_space_oe(link.transmit_space_oe),
      .receive_data_waiting_oe(link.receive_data_waiting_oe),
      .receive_data_waiting_pin(link.receive_data_waiting_pin),
      .power_switch_enable_n(link.power_switch_enable_n), .pull_low(link.pull_low),
      .usb_configured_in, .usb_suspend_in, .remote_wakeup_en_in, .suspend_pulldown_en_in,
      .resume_request_out);

   //---------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------
   // Clock of 25 ns
   always #12.5 sys_clk_in = ~sys_clk_in;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs

   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask : cyc

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // One cycle of a bounded wait
   task automatic step();
      cyc(1);
      n++;
      if (n > 500) begin
         mismatches++;
         $display("mismatch at %0t: wait timed out", $time);
         print_verdict();
      end
   endtask : step

   //---------------------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------------------
   initial begin
      {rx_valid_in, tx_ready_in, usb_configured_in, usb_suspend_in, remote_wakeup_en_in} = '0;
      {suspend_pulldown_en_in, send_valid_in, recv_req_in, wake_req_in} = '0;
      rx_data_in = '0;
      send_data_in = '0;
      // Real falling reset edge so every flop but the buffer storage clears before the first clock
      #1 arst_n_in = 1'b0;
      cyc(6);
      `CHK(link.transmit_space_pin, 1'b1)
      `CHK(link.receive_data_waiting_pin, 1'b1)
      cyc(6);
      arst_n_in = 1'b1;
      usb_configured_in = 1'b1;
      cyc(3);
      `CHK(link.power_switch_enable_n, 1'b0)
      `CHK(link.fifo_data_bus, 8'hff)
      // Receive buffer filled until it refuses
      rx_valid_in = 1'b1;
      for (i = 0; i < 12; i++) begin
         rnd = xs(rnd);
         rx_data_in = rnd[7:0];
         if (rx_ready_out)
            q.push_back(rx_data_in);
         cyc(1);
      end
      rx_valid_in = 1'b0;
      cyc(2);
      `CHK(q.size(), 8)
      `CHK(link.receive_data_waiting_pin, 1'b0)
      recv_req_in = 1'b1;
      while (q.size() > 0) begin
         n = 0;
         while (recv_valid_out !== 1'b1)
            step();
         `CHK(recv_data_out, q[0])
         q.delete(0);
         cyc(1);
      end
      recv_req_in = 1'b0;
      cyc(8);
      `CHK(link.receive_data_waiting_pin, 1'b1)
      // Transmit buffer filled while the USB side stalls
      send_valid_in = 1'b1;
      for (i = 0; i < 10; i++) begin
         rnd = xs(rnd);
         send_data_in = rnd[7:0];
         n = 0;
         while (link.wr !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
         end
         if (n < 40)
            q.push_back(send_data_in);
         else
            `CHK(i >= 8, 1'b1)
         cyc(4);
      end
      send_valid_in = 1'b0;
      `CHK(q.size(), 8)
      `CHK(link.transmit_space_pin, 1'b1)
      `CHK(send_ready_out, 1'b1)
      tx_ready_in = 1'b1;
      while (q.size() > 0) begin
         n = 0;
         while (tx_valid_out !== 1'b1)
            step();
         `CHK(tx_data_out, q[0])
         q.delete(0);
         cyc(1);
      end
      // Suspend with pins pulled low, then remote wakeup
      suspend_pulldown_en_in = 1'b1;
      usb_suspend_in = 1'b1;
      cyc(3);
      `CHK(link.power_switch_enable_n, 1'b1)
      `CHK(link_suspended_out, 1'b1)
      `CHK(link.fifo_data_bus, 8'h00)
      suspend_pulldown_en_in = 1'b0;
      cyc(2);
      remote_wakeup_en_in = 1'b1;
      cyc(3);
      `CHK(link.receive_data_waiting_oe, 1'b0)
      `CHK(link.fifo_data_bus, 8'hff)
      wake_req_in = 1'b1;
      n = 0;
      while (resume_request_out !== 1'b1)
         step();
      `CHK(n >= 20, 1'b1)
      print_verdict();
   end
endmodule : testbench
